// ===== cqs_consts.svh
// Purpose: Shared constants for the request stream port
// Assumes: Included by bare name wherever a figure is needed
// Notes:   Definitions only
`ifndef CQS_CONSTS_SVH
`define CQS_CONSTS_SVH

`define CQS_BUS_MAX       256
`define CQS_BUS_MID       128
`define CQS_BUS_MIN       64
`define CQS_DW_BITS       32
`define CQS_KEEP_W        8
`define CQS_CNT_W         4
`define CQS_SB_W          85
`define CQS_SOP_BIT       40
`define CQS_CREDIT_W      6
`define CQS_CREDIT_MAX    6'h20
`define CQS_CREDIT_ONE    6'h01
`define CQS_CREDIT_ZERO   6'h00

`endif

// ===== cqs_pkg.sv
// Purpose: Types for the request stream port
// Assumes: cqs_consts.svh supplies the widths
// Notes:   Holds types only
`include "cqs_consts.svh"

package cqs_pkg;

    // ****************************************
    // Arbiter states
    // ****************************************
    typedef enum logic [1:0]
    {
        cqs_st_idle,
        cqs_st_post,
        cqs_st_np
    } cqs_arb_state_t;

    // ****************************************
    // One outbound beat
    // ****************************************
    typedef struct packed
    {
        logic [`CQS_BUS_MAX-1:0] payload;
        logic                    final_beat;
        logic [`CQS_KEEP_W-1:0]  keep;
        logic [`CQS_SB_W-1:0]    sideband;
    } cqs_beat_t;

    // ****************************************
    // One inbound beat from the link side
    // ****************************************
    typedef struct packed
    {
        logic [`CQS_BUS_MAX-1:0] payload;
        logic                    final_beat;
        logic [`CQS_CNT_W-1:0]   last_dwords;
    } cqs_src_t;

endpackage : cqs_pkg

// ===== cqs_skid_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock; ce freezes all state
// Notes:   Outputs come from flops; a stall downstream loses no word
`timescale 1ns/1ps

module cqs_skid_buf #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic         skid_v_q;
    logic [W-1:0] skid_q;
    logic         out_v_q;
    logic [W-1:0] out_q;
    wire          in_take;
    wire          out_free;

    // ****************************************
    // Handshake terms
    // ****************************************
    // Ready hangs on a flop only, so no path runs from out_ready to in_ready
    assign in_ready  = !skid_v_q;
    assign in_take   = in_valid && !skid_v_q;
    assign out_free  = out_ready || !out_v_q;
    assign out_valid = out_v_q;
    assign out_data  = out_q;

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_v_q  <= 1'b0;
            out_q    <= '0;
            skid_v_q <= 1'b0;
            skid_q   <= '0;
        end
        else if (ce)
        begin
            if (out_free)
            begin
                out_v_q  <= skid_v_q || in_take;
                out_q    <= skid_v_q ? skid_q : in_data;
                skid_v_q <= 1'b0;
            end
            else if (in_take)
            begin
                skid_q   <= in_data;
                skid_v_q <= 1'b1;
            end
        end
    end

endmodule : cqs_skid_buf

// ===== cqs_req_port.sv
// Purpose: Outbound request stream with non-posted credit pacing
// Assumes: Link-side sources deliver each packet's beats without gaps
// Notes:   Posted and non-posted requests arrive on separate sources
//          Credit is spent as a non-posted packet enters the buffer, so the level
//          can read one lower while that packet still waits downstream
//          Source readies drop while ce is low, so a frozen buffer drops no beat
//          A last-beat Dword count outside one to the bus width reads as a full beat
//          The stream side must not take beats while ce is low: the buffer cannot pop
//          A width other than 64, 128 or 256 falls back to the next legal one below, or to 64 if under 64
//
// Contract
// - Final-beat flag is set on the beat ending each packet.
// - A one-beat packet carries the final-beat flag on that beat.
// - Dword-valid vector has one bit per 32-bit Dword of the bus.
// - Dword-valid bits are contiguous from first descriptor to last payload Dword.
// - All Dword-valid bits set on every beat but the last.
// - Unused Dword-valid bits tie low for 128-bit and 64-bit buses.
// - Valid is high whenever valid data is driven.
// - Valid stays high for a whole packet, no idle gaps.
// - A beat moves only when valid and ready are both high.
// - While stalled, data and qualifiers hold and valid stays high.
// - Credit count rises in each cycle the grant input is high.
// - Credit count falls by one per non-posted request delivered.
// - Non-posted requests start only while credit is non-zero.
// - Posted requests keep flowing while non-posted ones wait for credit.
// - Grant pulses are accepted in any cycle, unaligned to packets.
// - Current credit count appears on a 6-bit output.
// - Credit count saturates at 32.
// - Credit output may lag a grant by a few cycles.
// - Data bus width is 64, 128 or 256 bits.
// - Sideband bit 40 marks the first beat of each packet.
`timescale 1ns/1ps
`include "cqs_consts.svh"

module cqs_req_port #(
    parameter int DATA_W = `CQS_BUS_MAX
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic                    post_in_valid,
    output logic                         post_in_ready,
    input  wire logic [`CQS_BUS_MAX-1:0] post_in_payload,
    input  wire logic                    post_in_final,
    input  wire logic [`CQS_CNT_W-1:0]   post_in_dwords,
    input  wire logic                    np_in_valid,
    output logic                         np_in_ready,
    input  wire logic [`CQS_BUS_MAX-1:0] np_in_payload,
    input  wire logic                    np_in_final,
    input  wire logic [`CQS_CNT_W-1:0]   np_in_dwords,
    output logic [`CQS_BUS_MAX-1:0]      req_stream_payload,
    output logic                         req_stream_final_beat,
    output logic [`CQS_KEEP_W-1:0]       req_stream_dword_valid,
    output logic [`CQS_SB_W-1:0]         req_stream_sideband,
    output logic                         req_stream_valid,
    input  wire logic                    req_stream_ready,
    input  wire logic                    nonposted_credit_grant,
    output logic [`CQS_CREDIT_W-1:0]     nonposted_credit_level
);

    // ****************************************
    // Configuration
    // ****************************************
    // Any other width falls back to the next legal one below it, or to 64 if under 64
    localparam int BUS_W  = (DATA_W >= `CQS_BUS_MAX) ? `CQS_BUS_MAX
                          : (DATA_W >= `CQS_BUS_MID) ? `CQS_BUS_MID : `CQS_BUS_MIN;
    // Active Dwords on the configured bus
    localparam int ACT_DW = BUS_W / `CQS_DW_BITS;
    // The same count, sized to the last-beat Dword field
    localparam logic [`CQS_CNT_W-1:0] ACT_DW_CNT = ACT_DW[`CQS_CNT_W-1:0];

    // ****************************************
    // Declarations
    // ****************************************
    cqs_pkg::cqs_arb_state_t state_q;
    cqs_pkg::cqs_arb_state_t state_d;
    logic                    last_np_q;
    logic                    last_np_d;
    logic                    grant_q;
    logic [`CQS_CREDIT_W-1:0] credit_q;
    logic [`CQS_CREDIT_W-1:0] credit_d;
    logic [`CQS_CREDIT_W-1:0] credit_after;

    cqs_pkg::cqs_src_t       post_src;
    cqs_pkg::cqs_src_t       np_src;
    cqs_pkg::cqs_src_t       cur_src;
    cqs_pkg::cqs_beat_t      beat;
    cqs_pkg::cqs_beat_t      out_beat;

    wire                     in_idle;
    wire                     credit_ok;
    wire                     np_eligible;
    wire                     pick_np_idle;
    wire                     pick_post_idle;
    wire                     sel_post;
    wire                     sel_np;
    wire                     cur_valid;
    wire                     buf_ready;
    wire                     take;
    wire                     take_last;
    wire                     np_start;
    wire                     out_valid;
    wire [`CQS_KEEP_W-1:0]   keep;
    wire [`CQS_BUS_MAX-1:0]  payload_masked;
    // Named decode terms
    wire                     in_post;
    wire                     in_np;
    wire                     np_turn;
    wire                     first_beat;
    wire                     dw_zero;
    wire                     dw_over;
    wire [`CQS_CNT_W-1:0]    last_dw;
    wire                     credit_spend;
    wire                     credit_full;
    wire                     credit_fill;

    // ****************************************
    // Source bundles
    // ****************************************
    assign post_src.payload     = post_in_payload;
    assign post_src.final_beat  = post_in_final;
    assign post_src.last_dwords = post_in_dwords;
    assign np_src.payload       = np_in_payload;
    assign np_src.final_beat    = np_in_final;
    assign np_src.last_dwords   = np_in_dwords;

    // ****************************************
    // Packet arbitration
    // ****************************************
    // Choices are made only between packets, so a packet never interleaves
    assign in_idle        = state_q == cqs_pkg::cqs_st_idle;
    assign credit_ok      = credit_q != `CQS_CREDIT_ZERO;
    assign np_eligible    = np_in_valid && credit_ok;
    // Non-posted wins a tie unless the last packet was non-posted, to avoid starvation
    assign np_turn        = !post_in_valid || !last_np_q;
    assign pick_np_idle   = in_idle && np_eligible && np_turn;
    // A non-posted stall never holds back posted traffic
    assign pick_post_idle = in_idle && post_in_valid && !pick_np_idle;
    assign in_post        = state_q == cqs_pkg::cqs_st_post;
    assign in_np          = state_q == cqs_pkg::cqs_st_np;
    assign sel_post       = in_post || pick_post_idle;
    assign sel_np         = in_np || pick_np_idle;

    assign cur_src   = sel_np ? np_src : post_src;
    assign cur_valid = (sel_post && post_in_valid) || (sel_np && np_in_valid);
    assign take      = cur_valid && buf_ready;
    assign take_last = take && cur_src.final_beat;
    assign np_start  = pick_np_idle && take;

    // ****************************************
    // Source readies and packet state
    // ****************************************
    // Ready drops with ce, since a frozen buffer would lose an offered beat;
    // only the selected source sees ready, so packets never interleave
    assign post_in_ready = ce && sel_post && buf_ready;
    assign np_in_ready   = ce && sel_np && buf_ready;

    always_comb
    begin
        state_d   = state_q;
        last_np_d = last_np_q;
        case (state_q)
            cqs_pkg::cqs_st_idle:
            begin
                if (take)
                begin
                    last_np_d = sel_np;
                    if (!cur_src.final_beat)
                    begin
                        state_d = sel_np ? cqs_pkg::cqs_st_np : cqs_pkg::cqs_st_post;
                    end
                end
            end
            cqs_pkg::cqs_st_post:
            begin
                if (take_last)
                begin
                    state_d = cqs_pkg::cqs_st_idle;
                end
            end
            cqs_pkg::cqs_st_np:
            begin
                if (take_last)
                begin
                    state_d = cqs_pkg::cqs_st_idle;
                end
            end
            default:
            begin
                state_d = cqs_pkg::cqs_st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= cqs_pkg::cqs_st_idle;
            last_np_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q   <= state_d;
            last_np_q <= last_np_d;
        end
    end

    // ****************************************
    // Last-beat Dword count
    // ****************************************
    // A zero or oversize count would break the contiguous fill,
    // so it reads as a full beat rather than an empty one
    assign dw_zero = cur_src.last_dwords == '0;
    assign dw_over = cur_src.last_dwords > ACT_DW_CNT;
    assign last_dw = (dw_zero || dw_over) ? ACT_DW_CNT
                   : cur_src.last_dwords;

    // ****************************************
    // Dword-valid vector and payload width
    // ****************************************
    // Bits past the configured bus stay low for narrow buses
    genvar gi;
    generate
        for (gi = 0; gi < `CQS_KEEP_W; gi = gi + 1)
        begin : g_keep
            if (gi < ACT_DW)
            begin : g_live
                localparam int POS = gi;
                // Full beats set every bit; the last beat fills from bit 0
                assign keep[gi] = !cur_src.final_beat
                                  || (last_dw > POS[`CQS_CNT_W-1:0]);
            end
            else
            begin : g_dead
                assign keep[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < `CQS_BUS_MAX; gi = gi + 1)
        begin : g_pay
            if (gi < BUS_W)
            begin : g_live
                assign payload_masked[gi] = cur_src.payload[gi];
            end
            else
            begin : g_dead
                assign payload_masked[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************
    // Beat assembly
    // ****************************************
    // Only an idle arbiter can be handing over a packet's first beat
    assign first_beat = in_idle;

    always_comb
    begin
        beat                        = '0;
        beat.payload                = payload_masked;
        beat.final_beat             = cur_src.final_beat;
        beat.keep                   = keep;
        beat.sideband[`CQS_SOP_BIT] = first_beat;
    end

    // ****************************************
    // Output buffer
    // ****************************************
    // Two entries absorb a ready drop without stalling the arbiter a cycle late
    cqs_skid_buf #(
        .W ($bits(cqs_pkg::cqs_beat_t))
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (cur_valid),
        .in_ready  (buf_ready),
        .in_data   (beat),
        .out_valid (out_valid),
        .out_ready (req_stream_ready),
        .out_data  (out_beat)
    );

    // Buffer holds its head until ready, so beats stay steady under stall
    assign req_stream_valid       = out_valid;
    assign req_stream_payload     = out_beat.payload;
    assign req_stream_final_beat  = out_beat.final_beat;
    assign req_stream_dword_valid = out_beat.keep;
    assign req_stream_sideband    = out_beat.sideband;

    // ****************************************
    // Non-posted credit
    // ****************************************
    // Grant is registered once; the level lags a grant by two edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grant_q <= 1'b0;
        end
        else if (ce)
        begin
            grant_q <= nonposted_credit_grant;
        end
    end

    // Spend is taken at packet start so a second packet cannot slip in
    assign credit_spend = np_start;
    assign credit_after = credit_spend ? credit_q - `CQS_CREDIT_ONE : credit_q;

    // Saturation is judged after the spend, so spend and grant together hold at the limit
    assign credit_full  = credit_after == `CQS_CREDIT_MAX;
    assign credit_fill  = grant_q && !credit_full;

    always_comb
    begin
        credit_d = credit_after;
        if (credit_fill)
        begin
            credit_d = credit_after + `CQS_CREDIT_ONE;
        end
    end

    // Reset empties the credit, so nothing non-posted moves before a grant
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            credit_q <= `CQS_CREDIT_ZERO;
        end
        else if (ce)
        begin
            credit_q <= credit_d;
        end
    end

    assign nonposted_credit_level = credit_q;

endmodule : cqs_req_port

// ===== cqs_req_port_chk.sv
// Purpose: Assertions on the request stream port
// Assumes: Sees only the top module's ports
// Notes:   Bound to every cqs_req_port
`timescale 1ns/1ps
`include "cqs_consts.svh"

module cqs_req_port_chk #(
    parameter int DATA_W = `CQS_BUS_MAX
) (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    np_in_valid,
    input wire logic                    np_in_ready,
    input wire logic                    np_in_final,
    input wire logic [`CQS_BUS_MAX-1:0] req_stream_payload,
    input wire logic                    req_stream_final_beat,
    input wire logic [`CQS_KEEP_W-1:0]  req_stream_dword_valid,
    input wire logic [`CQS_SB_W-1:0]    req_stream_sideband,
    input wire logic                    req_stream_valid,
    input wire logic                    req_stream_ready,
    input wire logic                    nonposted_credit_grant,
    input wire logic [`CQS_CREDIT_W-1:0] nonposted_credit_level
);
    // ****
    // Helpers
    // ****
    localparam logic [7:0] FULL = 8'((1 << (DATA_W / 32)) - 1);
    logic       first_q;
    logic       np_mid_q;
    wire        v  = req_stream_valid;
    wire        fb = req_stream_final_beat;
    wire  [7:0] kp = req_stream_dword_valid;
    wire  [5:0] lv = nonposted_credit_level;
    wire        np_start = np_in_valid && np_in_ready && !np_mid_q;
    wire        xfer = v && req_stream_ready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Tracks packet starts on both sides, since sop and credit spend key off them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_q  <= 1'b1;
            np_mid_q <= 1'b0;
        end
        else
        begin
            if (xfer)
                first_q <= fb;
            if (np_in_valid && np_in_ready)
                np_mid_q <= !np_in_final;
        end
    end

    // ****
    // Checks
    // ****
    a_stall_hold: assert property (v && !req_stream_ready |=> v && $stable(req_stream_payload) && $stable(fb)
        && $stable(kp) && $stable(req_stream_sideband)) else $error("stalled beat changed");
    a_no_gap: assert property (xfer && !fb |=> v) else $error("gap inside packet");
    a_keep_full: assert property (v && !fb |-> kp == FULL) else $error("partial keep mid packet");
    a_keep_unused: assert property ((kp & ~FULL) == 8'h00) else $error("unused keep bit set");
    a_keep_contig: assert property (v |-> kp != 8'h00 && ((kp + 8'h01) & kp) == 8'h00)
        else $error("keep not contiguous");
    a_sop_first: assert property (v |-> req_stream_sideband[`CQS_SOP_BIT] == first_q) else $error("bad sop");
    a_credit_up: assert property (lv > $past(lv) |-> $past(nonposted_credit_grant, 2)
        && lv == $past(lv) + `CQS_CREDIT_ONE) else $error("credit rose without grant");
    a_credit_down: assert property (lv < $past(lv) |-> $past(np_start) && lv == $past(lv) - `CQS_CREDIT_ONE)
        else $error("credit fell without spend");
    a_credit_gate: assert property (np_start |-> lv != `CQS_CREDIT_ZERO) else $error("np start at zero");
    a_credit_max: assert property (lv <= `CQS_CREDIT_MAX) else $error("credit above limit");

    c_stall: cover property (v && !req_stream_ready);
    c_np_start: cover property (np_start);
    c_credit_full: cover property (lv == `CQS_CREDIT_MAX);
endmodule : cqs_req_port_chk

bind cqs_req_port cqs_req_port_chk #(.DATA_W(DATA_W)) u_chk (.clk, .rst_n, .np_in_valid, .np_in_ready,
    .np_in_final, .req_stream_payload, .req_stream_final_beat, .req_stream_dword_valid, .req_stream_sideband,
    .req_stream_valid, .req_stream_ready, .nonposted_credit_grant, .nonposted_credit_level);

// ===== cqs_user_model.sv
// Purpose: User logic that consumes requests and grants credit
// Assumes: Changes its outputs only just after a rising edge
// Notes:   Stalls at random when asked to
`timescale 1ns/1ps

module cqs_user_model (
    input  wire logic clk,
    input  wire logic stall_en,
    input  wire logic grant_hold,
    input  wire logic grant_kick,
    output logic      ready = 1'b0,
    output logic      grant = 1'b0
);
    // Takes requests only and never hands a completion tag back for reuse

    // Kick gives lone pulses, hold gives a level, neither tied to packets
    always @(posedge clk)
    begin
        ready <= !stall_en || ($urandom % 3 != 0);
        grant <= grant_hold || (grant_kick && !grant);
    end
endmodule : cqs_user_model

// ===== cqs_req_port_bench.sv
// Purpose: Self-checking bench for the request stream port
// Assumes: 128-bit bus, clock enable held high
// Notes:   Kind of packet rides in payload bit 127
`timescale 1ns/1ps
`include "cqs_consts.svh"

module cqs_req_port_bench;
    // ****
    // Wiring
    // ****
    localparam int         DW   = 128;
    localparam logic [7:0] FULL = 8'((1 << (DW / 32)) - 1);
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        src_v [2] = '{1'b0, 1'b0};
    logic        src_f [2] = '{1'b0, 1'b0};
    logic [3:0]  src_d [2] = '{4'h1, 4'h1};
    logic [255:0] src_p [2] = '{256'h0, 256'h0};
    logic        src_r [2];
    logic [255:0] o_p;
    logic        o_f, o_v, o_r, grant, stall_en = 1'b1, g_hold = 1'b0, g_kick = 1'b0;
    logic [7:0]  o_k;
    logic [84:0] o_s;
    logic [5:0]  lvl;
    cqs_pkg::cqs_beat_t exp_q [2][$];
    int          n_out [2] = '{0, 0};
    int          error_cnt = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;

    cqs_req_port #(.DATA_W(DW)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .post_in_valid(src_v[0]), .post_in_ready(src_r[0]), .post_in_payload(src_p[0]),
        .post_in_final(src_f[0]), .post_in_dwords(src_d[0]), .np_in_valid(src_v[1]), .np_in_ready(src_r[1]),
        .np_in_payload(src_p[1]), .np_in_final(src_f[1]), .np_in_dwords(src_d[1]), .req_stream_payload(o_p),
        .req_stream_final_beat(o_f), .req_stream_dword_valid(o_k), .req_stream_sideband(o_s),
        .req_stream_valid(o_v), .req_stream_ready(o_r), .nonposted_credit_grant(grant),
        .nonposted_credit_level(lvl));

    cqs_user_model u_user (.clk(clk), .stall_en(stall_en), .grant_hold(g_hold), .grant_kick(g_kick),
        .ready(o_r), .grant(grant));

    // ****
    // Helpers
    // ****
    task automatic chk(input string nm, input logic [511:0] e, input logic [511:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    function automatic logic [7:0] exp_keep(input logic f, input int dw);
        return f ? 8'((1 << dw) - 1) : FULL;
    endfunction : exp_keep

    task automatic send(input int s, input int nb, input int dw);
        cqs_pkg::cqs_beat_t e;
        for (int i = 0; i < nb; i++)
        begin
            src_p[s] = {128'h0, s[0], 127'({$urandom, $urandom, $urandom, $urandom})};
            src_v[s] = 1'b1;
            src_f[s] = (i == nb - 1);
            src_d[s] = 4'(dw);
            e = '{src_p[s], src_f[s], exp_keep(src_f[s], dw), 85'(i == 0) << `CQS_SOP_BIT};
            do @(posedge clk); while (src_r[s] !== 1'b1);
            exp_q[s].push_back(e);
            @(negedge clk);
        end
        src_v[s] = 1'b0;
        // One edge passes with valid low before the next packet raises it again
        @(negedge clk);
    endtask : send

    task automatic drain();
        for (int i = 0; i < 600 && exp_q[0].size() + exp_q[1].size() != 0; i++)
            @(negedge clk);
        chk("left", 512'h0, 512'(exp_q[0].size() + exp_q[1].size()));
    endtask : drain

    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Every delivered beat is matched against its source's queue
    always @(posedge clk)
    begin
        if (rst_n && o_v === 1'b1 && o_r === 1'b1)
        begin
            if (exp_q[o_p[127]].size() == 0)
                chk("extra", 512'h0, 512'h1);
            else
                chk("beat", 512'(exp_q[o_p[127]].pop_front()), 512'({o_p, o_f, o_k, o_s}));
            n_out[o_p[127]]++;
        end
    end

    // ****
    // Tests
    // ****
    initial
    begin
        void'($urandom(87));
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk("level", 512'h0, 512'(lvl));
        chk("valid", 512'h0, 512'(o_v));
        send(0, 1, 3);
        repeat (30) send(0, 1 + $urandom % 4, 1 + $urandom % 4);
        drain();
        fork
            send(1, 2, 3);
        join_none
        repeat (6) send(0, 1 + $urandom % 3, 1 + $urandom % 4);
        drain();
        chk("np held", 512'h0, 512'(n_out[1]));
        g_kick = 1'b1;
        @(negedge clk);
        g_kick = 1'b0;
        repeat (60) @(negedge clk);
        chk("np sent", 512'h2, 512'(n_out[1]));
        chk("level", 512'h0, 512'(lvl));
        g_hold = 1'b1;
        repeat (40) @(negedge clk);
        chk("level", 512'h20, 512'(lvl));
        fork
            repeat (20) send(0, 1 + $urandom % 4, 1 + $urandom % 4);
            repeat (20) send(1, 1 + $urandom % 4, 1 + $urandom % 4);
        join
        g_hold = 1'b0;
        drain();
        repeat (4) @(negedge clk);
        chk("level", 512'h20, 512'(lvl));
        end_sim();
    end

    initial
    begin
        #(20000 * 100);
        error_cnt++;
        end_sim();
    end
endmodule : cqs_req_port_bench
